// file: core/gpc_pkg.sv
package gpc_pkg;

    localparam int CLK_HZ         = 100_000_000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int DUTY_STEPS     = 200;

    // one slot is one half percent of the modulation period
    localparam int FREQ_5K_HZ     = 5000;
    localparam int FREQ_10K_HZ    = 10000;
    localparam int FREQ_20K_HZ    = 20000;
    localparam int SLOT_5K_CYC    = CLK_HZ / (FREQ_5K_HZ * DUTY_STEPS);
    localparam int SLOT_10K_CYC   = CLK_HZ / (FREQ_10K_HZ * DUTY_STEPS);
    localparam int SLOT_20K_CYC   = CLK_HZ / (FREQ_20K_HZ * DUTY_STEPS);

    localparam int TICKLE_GAP_NS     = 200_000;
    localparam int TICKLE_GAP_CYC    = (TICKLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKLE_PULSE_NS   = 1000;
    localparam int TICKLE_PULSE_CYC  = TICKLE_PULSE_NS / CLK_PERIOD_NS;
    localparam int VERSION_SCREEN_NS = 1_000_000_000;
    localparam int VERSION_CYC       = VERSION_SCREEN_NS / CLK_PERIOD_NS;

    typedef logic [7:0]  gpc_duty_t;
    typedef logic [6:0]  gpc_sub_t;
    typedef logic [15:0] gpc_off_t;
    typedef logic [26:0] gpc_ver_t;

    localparam gpc_duty_t DUTY_MAX_95  = 8'hbe;
    localparam gpc_duty_t DUTY_MAX_99  = 8'hc6;
    localparam gpc_duty_t STEP_FINE    = 8'h01;
    localparam gpc_duty_t STEP_COARSE  = 8'h0a;
    localparam gpc_duty_t DUTY_RESET   = 8'h00;

    typedef enum logic [1:0] {FR_5K = 2'h0, FR_10K = 2'h1, FR_20K = 2'h2} gpc_freq_t;

    typedef enum logic [2:0] {
        ST_BOOT_RD = 3'h0, ST_BOOT_LD = 3'h1, ST_RUN = 3'h2,
        ST_MENU    = 3'h3, ST_EDIT    = 3'h4, ST_SAVE = 3'h5
    } gpc_state_t;

    typedef enum logic [2:0] {
        IT_FREQ = 3'h0, IT_GATE = 3'h1, IT_MAXPWM = 3'h2, IT_AUTOSTART = 3'h3, IT_SAVE = 3'h4
    } gpc_item_t;

    typedef struct packed {
        logic      autostart;
        logic      max99;
        logic      gate_pd;
        gpc_freq_t freq;
    } gpc_cfg_t;

    localparam gpc_cfg_t CFG_DEFAULT = 5'h00;

    typedef struct packed {
        logic [7:0] sig;
        gpc_duty_t  duty;
        logic [2:0] pad;
        gpc_cfg_t   cfg;
    } gpc_nvm_word_t;

    // marks a word that was really written, not a board identity
    localparam logic [7:0] NVM_SIG      = 8'ha5;
    localparam logic [1:0] NVM_CFG_ADDR = 2'h0;

    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_DUTY   = 8'h04;
    localparam logic [7:0] OFF_CONFIG = 8'h08;
    localparam logic [7:0] OFF_CTRL   = 8'h0c;
    localparam int CTRL_TOGGLE_BIT = 0;
    localparam int CTRL_SAVE_BIT   = 1;

endpackage

// file: core/gpc_pwm_if.sv
`timescale 1ns/100ps
interface gpc_pwm_if;
    gpc_pkg::gpc_freq_t freq;
    gpc_pkg::gpc_duty_t duty;
    logic               pwm_raw;

    modport ctl (output freq, output duty, input pwm_raw);
    modport tb  (input freq, input duty, output pwm_raw);
endinterface

// file: core/gpc_nvm_store.sv
`timescale 1ns/100ps
module gpc_nvm_store (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    input  wire logic [1:0]            addr_i,
    input  wire gpc_pkg::gpc_nvm_word_t wdata_i,
    output gpc_pkg::gpc_nvm_word_t     rdata_o
);
    // array has no reset: contents survive a reset like nonvolatile cells
    gpc_pkg::gpc_nvm_word_t mem [4];

    always_ff @(posedge core_clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else if (re_i)
        begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// file: core/gpc_pwm_timebase.sv
`timescale 1ns/100ps
module gpc_pwm_timebase (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    gpc_pwm_if.tb     pwm
);
    gpc_pkg::gpc_sub_t  sub_cnt;
    gpc_pkg::gpc_sub_t  next_sub_cnt;
    gpc_pkg::gpc_duty_t slot_cnt;
    gpc_pkg::gpc_duty_t next_slot_cnt;
    gpc_pkg::gpc_sub_t  slot_len;
    logic               raw;
    logic               next_raw;

    assign pwm.pwm_raw = raw;

    always_comb
    begin
        case (pwm.freq)
            gpc_pkg::FR_10K: slot_len = gpc_pkg::gpc_sub_t'(gpc_pkg::SLOT_10K_CYC);
            gpc_pkg::FR_20K: slot_len = gpc_pkg::gpc_sub_t'(gpc_pkg::SLOT_20K_CYC);
            default:         slot_len = gpc_pkg::gpc_sub_t'(gpc_pkg::SLOT_5K_CYC);
        endcase
        // free running; >= keeps a shortened slot from overrunning after a rate change
        next_sub_cnt  = sub_cnt + 7'h01;
        next_slot_cnt = slot_cnt;
        if (sub_cnt >= slot_len - 7'h01)
        begin
            next_sub_cnt  = '0;
            next_slot_cnt = (slot_cnt == gpc_pkg::gpc_duty_t'(gpc_pkg::DUTY_STEPS - 1)) ? '0 : slot_cnt + 8'h01;
        end
        next_raw = (next_slot_cnt < pwm.duty);
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sub_cnt  <= '0;
            slot_cnt <= '0;
            raw      <= 1'b0;
        end
        else
        begin
            sub_cnt  <= next_sub_cnt;
            slot_cnt <= next_slot_cnt;
            raw      <= next_raw;
        end
    end
endmodule

// file: core/gpc_laser_pwm.sv
// Behaviour
// - rate selectable: 5, 10 or 20 kHz
// - rate defaults to 5 kHz
// - fire only when enabled and gate active
// - tickle pulse after 200 us off
// - gate mode defaults to pull-up
// - pull-up: active unless held low
// - pull-down: fire only on high gate
// - pull-down: floating gate reads inactive
// - pulse train free running, not gate-aligned
// - max duty limit 95 or 99 percent
// - max duty limit defaults to 95
// - knob detent 0.5 percent, pressed 5
// - select+confirm or boot confirm enters setup
// - select steps items; save stores all
// - lasing off after power-up by default
// - autostart sets lase-enable at power-up
// - later start-ups restore saved parameters
// - duty held in half-percent steps
// - lase button inverts lase-enable
// - disabled: standby, tickle pulses only
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module gpc_laser_pwm #(
    parameter int TICKLE_GAP_CYC = gpc_pkg::TICKLE_GAP_CYC,
    parameter int VERSION_CYC    = gpc_pkg::VERSION_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        gate_i,
    input  wire logic        btn_select_i,
    input  wire logic        btn_confirm_i,
    input  wire logic        btn_lase_i,
    input  wire logic        knob_step_i,
    input  wire logic        knob_up_i,
    input  wire logic        knob_press_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             laser_cmd_o,
    output logic             lase_led_o,
    output logic             gate_pull_up_o,
    output logic             setup_active_o,
    output logic [2:0]       menu_item_o,
    output logic [7:0]       duty_o
);
    gpc_pkg::gpc_state_t    state;
    gpc_pkg::gpc_state_t    next_state;
    gpc_pkg::gpc_item_t     item;
    gpc_pkg::gpc_item_t     next_item;
    gpc_pkg::gpc_cfg_t      cfg;
    gpc_pkg::gpc_cfg_t      next_cfg;
    gpc_pkg::gpc_duty_t     duty;
    gpc_pkg::gpc_duty_t     next_duty;
    gpc_pkg::gpc_duty_t     lim;
    gpc_pkg::gpc_duty_t     step;
    logic [8:0]             sum9;
    logic                   lase_en;
    logic                   next_lase_en;
    gpc_pkg::gpc_ver_t      ver_cnt;
    gpc_pkg::gpc_ver_t      next_ver_cnt;
    logic                   nvm_we;
    logic                   next_nvm_we;
    gpc_pkg::gpc_nvm_word_t nvm_rd;
    gpc_pkg::gpc_nvm_word_t nvm_wd;
    logic                   sel_q;
    logic                   cfm_q;
    logic                   lase_q;
    logic                   sel_rise;
    logic                   cfm_rise;
    logic                   lase_rise;

    logic                   gate_act;
    logic                   fire_out;
    logic                   next_fire_out;
    logic                   tickle;
    logic                   next_tickle;
    gpc_pkg::gpc_off_t      off_cnt;
    gpc_pkg::gpc_off_t      next_off_cnt;
    gpc_pkg::gpc_sub_t      tick_cnt;
    gpc_pkg::gpc_sub_t      next_tick_cnt;

    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic                   hit;
    logic                   wr_commit;

    gpc_pwm_if pwm ();

    gpc_pwm_timebase u_timebase (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pwm        (pwm.tb)
    );

    assign nvm_wd = {gpc_pkg::NVM_SIG, duty, 3'h0, cfg};

    gpc_nvm_store u_nvm (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .we_i       (nvm_we),
        .re_i       (state == gpc_pkg::ST_BOOT_RD),
        .addr_i     (gpc_pkg::NVM_CFG_ADDR),
        .wdata_i    (nvm_wd),
        .rdata_o    (nvm_rd)
    );

    assign pwm.freq  = cfg.freq;
    assign pwm.duty  = duty;
    assign sel_rise  = btn_select_i & ~sel_q;
    assign cfm_rise  = btn_confirm_i & ~cfm_q;
    assign lase_rise = btn_lase_i & ~lase_q;
    // a write lands at the edge where the master sees pready
    assign wr_commit = psel & penable & pwrite & pready & ~pslverr;

    // control: setup menu, parameters, lase enable, nonvolatile save
    always_comb
    begin
        next_state   = state;
        next_item    = item;
        next_cfg     = cfg;
        next_duty    = duty;
        next_lase_en = lase_en;
        next_nvm_we  = 1'b0;
        next_ver_cnt = (ver_cnt != '0) ? ver_cnt - 27'h0000001 : ver_cnt;
        step         = knob_press_i ? gpc_pkg::STEP_COARSE : gpc_pkg::STEP_FINE;
        lim          = cfg.max99 ? gpc_pkg::DUTY_MAX_99 : gpc_pkg::DUTY_MAX_95;
        sum9         = {1'b0, duty} + {1'b0, step};
        case (state)
            gpc_pkg::ST_BOOT_RD:
            begin
                next_state = gpc_pkg::ST_BOOT_LD;
            end
            gpc_pkg::ST_BOOT_LD:
            begin
                if (nvm_rd.sig == gpc_pkg::NVM_SIG)
                begin
                    next_cfg     = nvm_rd.cfg;
                    next_duty    = nvm_rd.duty;
                    next_lase_en = nvm_rd.cfg.autostart;
                end
                next_state = gpc_pkg::ST_RUN;
            end
            gpc_pkg::ST_RUN:
            begin
                if ((btn_select_i && btn_confirm_i) || (btn_confirm_i && ver_cnt != '0))
                begin
                    next_state = gpc_pkg::ST_MENU;
                    next_item  = gpc_pkg::IT_FREQ;
                end
                else
                begin
                    if (lase_rise)
                    begin
                        next_lase_en = ~lase_en;
                    end
                    if (knob_step_i && knob_up_i)
                    begin
                        next_duty = (sum9 > {1'b0, lim}) ? lim : sum9[7:0];
                    end
                    else if (knob_step_i)
                    begin
                        next_duty = (duty < step) ? '0 : duty - step;
                    end
                end
            end
            gpc_pkg::ST_MENU:
            begin
                if (sel_rise)
                begin
                    next_item = (item == gpc_pkg::IT_SAVE) ? gpc_pkg::IT_FREQ
                                                            : gpc_pkg::gpc_item_t'(item + 3'h1);
                end
                else if (cfm_rise)
                begin
                    next_state = (item == gpc_pkg::IT_SAVE) ? gpc_pkg::ST_SAVE : gpc_pkg::ST_EDIT;
                end
            end
            gpc_pkg::ST_EDIT:
            begin
                if (sel_rise)
                begin
                    case (item)
                        gpc_pkg::IT_FREQ:
                        begin
                            next_cfg.freq = (cfg.freq == gpc_pkg::FR_5K)  ? gpc_pkg::FR_10K :
                                            (cfg.freq == gpc_pkg::FR_10K) ? gpc_pkg::FR_20K : gpc_pkg::FR_5K;
                        end
                        gpc_pkg::IT_GATE:      next_cfg.gate_pd   = ~cfg.gate_pd;
                        gpc_pkg::IT_MAXPWM:    next_cfg.max99     = ~cfg.max99;
                        gpc_pkg::IT_AUTOSTART: next_cfg.autostart = ~cfg.autostart;
                        default:               next_cfg = cfg;
                    endcase
                end
                else if (cfm_rise)
                begin
                    next_state = gpc_pkg::ST_MENU;
                end
            end
            gpc_pkg::ST_SAVE:
            begin
                next_nvm_we = 1'b1;
                next_state  = gpc_pkg::ST_RUN;
            end
            default:
            begin
                next_state = gpc_pkg::ST_BOOT_RD;
            end
        endcase
        if (wr_commit && paddr == gpc_pkg::OFF_DUTY)
        begin
            next_duty = pwdata[7:0];
        end
        if (wr_commit && paddr == gpc_pkg::OFF_CONFIG)
        begin
            next_cfg = pwdata[4:0];
        end
        if (wr_commit && paddr == gpc_pkg::OFF_CTRL && pwdata[gpc_pkg::CTRL_TOGGLE_BIT])
        begin
            next_lase_en = ~next_lase_en;
        end
        if (wr_commit && paddr == gpc_pkg::OFF_CTRL && pwdata[gpc_pkg::CTRL_SAVE_BIT]
            && state == gpc_pkg::ST_RUN)
        begin
            next_state = gpc_pkg::ST_SAVE;
        end
        // limit may have dropped to 95 or a raw value come in: clamp last
        if (next_duty > (next_cfg.max99 ? gpc_pkg::DUTY_MAX_99 : gpc_pkg::DUTY_MAX_95))
        begin
            next_duty = next_cfg.max99 ? gpc_pkg::DUTY_MAX_99 : gpc_pkg::DUTY_MAX_95;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state   <= gpc_pkg::ST_BOOT_RD;
            item    <= gpc_pkg::IT_FREQ;
            cfg     <= gpc_pkg::CFG_DEFAULT;
            duty    <= gpc_pkg::DUTY_RESET;
            lase_en <= 1'b0;
            ver_cnt <= gpc_pkg::gpc_ver_t'(VERSION_CYC);
            nvm_we  <= 1'b0;
            sel_q   <= 1'b0;
            cfm_q   <= 1'b0;
            lase_q  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            item    <= next_item;
            cfg     <= next_cfg;
            duty    <= next_duty;
            lase_en <= next_lase_en;
            ver_cnt <= next_ver_cnt;
            nvm_we  <= next_nvm_we;
            sel_q   <= btn_select_i;
            cfm_q   <= btn_confirm_i;
            lase_q  <= btn_lase_i;
        end
    end

    // output path: gate, firing, tickle
    always_comb
    begin
        // the pull resistor chosen below decides what an open pin reads
        next_fire_out = lase_en & gate_act & pwm.pwm_raw;
        next_off_cnt  = '0;
        next_tick_cnt = '0;
        if (!next_fire_out)
        begin
            if (tick_cnt != '0)
            begin
                next_tick_cnt = tick_cnt - 7'h01;
            end
            else if (off_cnt == gpc_pkg::gpc_off_t'(TICKLE_GAP_CYC - 1))
            begin
                next_tick_cnt = gpc_pkg::gpc_sub_t'(gpc_pkg::TICKLE_PULSE_CYC);
            end
            else
            begin
                next_off_cnt = off_cnt + 16'h0001;
            end
        end
        next_tickle = (next_tick_cnt != '0);
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gate_act       <= 1'b0;
            fire_out       <= 1'b0;
            tickle         <= 1'b0;
            off_cnt        <= '0;
            tick_cnt       <= '0;
            laser_cmd_o    <= 1'b0;
            lase_led_o     <= 1'b0;
            gate_pull_up_o <= 1'b1;
            setup_active_o <= 1'b0;
            menu_item_o    <= '0;
            duty_o         <= '0;
        end
        else
        begin
            gate_act       <= gate_i;
            fire_out       <= next_fire_out;
            tickle         <= next_tickle;
            off_cnt        <= next_off_cnt;
            tick_cnt       <= next_tick_cnt;
            laser_cmd_o    <= next_fire_out | next_tickle;
            lase_led_o     <= lase_en & gate_act;
            gate_pull_up_o <= ~cfg.gate_pd;
            setup_active_o <= (state == gpc_pkg::ST_MENU) || (state == gpc_pkg::ST_EDIT);
            menu_item_o    <= item;
            duty_o         <= duty;
        end
    end

    // APB slave, one wait state, unmapped offsets answer pslverr
    always_comb
    begin
        hit         = 1'b1;
        next_prdata = '0;
        case (paddr)
            gpc_pkg::OFF_STATUS: next_prdata = {21'h0, item, 2'h0, laser_cmd_o, gate_act, lase_en, state};
            gpc_pkg::OFF_DUTY:   next_prdata = {24'h000000, duty};
            gpc_pkg::OFF_CONFIG: next_prdata = {27'h0, cfg};
            gpc_pkg::OFF_CTRL:   next_prdata = '0;
            default:             hit = 1'b0;
        endcase
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & ~hit;
        if (!next_pready || pwrite || !hit)
        begin
            next_prdata = '0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_fire_needs_both: assert property (fire_out |-> $past(lase_en) && $past(gate_act))
        else $error("firing without lase enable and active gate");
    a_standby_no_fire: assert property (!lase_en ##1 !lase_en |-> !fire_out)
        else $error("firing pulse while lase disabled");
    // the edge that releases reset still resets the flop, so that edge is skipped
    a_gate_follows: assert property (!$past(rst_i) |-> gate_act == $past(gate_i))
        else $error("gate activity does not follow the gate pin");
    a_tickle_gap: assert property (!fire_out && tick_cnt == '0 && !next_fire_out
        && off_cnt == gpc_pkg::gpc_off_t'(TICKLE_GAP_CYC - 1) |=> tickle && laser_cmd_o)
        else $error("no tickle after the off gap");
    a_duty_limit: assert property (duty <= (cfg.max99 ? gpc_pkg::DUTY_MAX_99 : gpc_pkg::DUTY_MAX_95))
        else $error("duty above the configured limit");
    a_lase_toggle: assert property (state == gpc_pkg::ST_RUN && lase_rise && !btn_confirm_i && !wr_commit
        |=> lase_en != $past(lase_en))
        else $error("lase button did not invert lase enable");
    a_fine_step: assert property (state == gpc_pkg::ST_RUN && knob_step_i && knob_up_i && !knob_press_i
        && !btn_confirm_i && !wr_commit && duty < lim |=> duty == $past(duty) + 8'h01)
        else $error("fine knob step is not one half percent");
    a_setup_entry: assert property (state == gpc_pkg::ST_RUN && btn_select_i && btn_confirm_i
        |=> state == gpc_pkg::ST_MENU ##1 setup_active_o)
        else $error("select and confirm did not enter setup");
    a_save_writes: assert property (state == gpc_pkg::ST_MENU && cfm_rise && !sel_rise
        && item == gpc_pkg::IT_SAVE |=> ##1 nvm_we ##1 state == gpc_pkg::ST_RUN)
        else $error("save and exit did not store parameters");
    a_boot_default: assert property (state == gpc_pkg::ST_BOOT_LD && nvm_rd.sig != gpc_pkg::NVM_SIG
        && !wr_commit |=> cfg.freq == gpc_pkg::FR_5K && !cfg.max99 && !cfg.gate_pd && !lase_en)
        else $error("fresh start-up did not use defaults");
    a_boot_restore: assert property (state == gpc_pkg::ST_BOOT_LD && nvm_rd.sig == gpc_pkg::NVM_SIG
        && !wr_commit |=> cfg == $past(nvm_rd.cfg) && lase_en == $past(nvm_rd.cfg.autostart))
        else $error("saved parameters not restored");

    c_tickle:  cover property (!lase_en ##1 tickle);
    c_fire:    cover property (fire_out ##1 !fire_out);
    c_save:    cover property (nvm_we);
    c_autorun: cover property (state == gpc_pkg::ST_BOOT_LD ##1 lase_en);
endmodule

// file: bench/gpc_rf_supply_model.sv
`timescale 1ns/100ps
module gpc_rf_supply_model (
    input  wire logic core_clk_i,
    input  wire logic cmd_i,
    input  wire logic clr_i,
    output int        max_hi_o
);
    int run = 0;

    // a pulse length is only known once it ends, so the longest finished one is kept
    always @(posedge core_clk_i)
    begin
        run <= cmd_i ? run + 1 : 0;
        if (clr_i)
            max_hi_o <= 0;
        else if (!cmd_i && run > max_hi_o)
            max_hi_o <= run;
    end
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic        core_clk_i = 0, rst_i = 1, gate_i = 1, clr = 0;
    logic        knob_step_i = 0, knob_up_i = 1, knob_press_i = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [2:0]  btn = 3'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_val;
    logic        pready, pslverr, rd_err, laser_cmd_o, lase_led_o, gate_pull_up_o, setup_active_o;
    logic [2:0]  menu_item_o;
    logic [7:0]  duty_o;
    int          err_count = 0, checks_done = 0, max_hi;
    int          slot [3] = '{gpc_pkg::SLOT_5K_CYC, gpc_pkg::SLOT_10K_CYC, gpc_pkg::SLOT_20K_CYC};

    // short tickle gap keeps runs brief; 300 leaves no tickle touching a 95 percent burst
    gpc_laser_pwm #(.TICKLE_GAP_CYC(300), .VERSION_CYC(20)) DUT (
        .core_clk_i, .rst_i, .gate_i, .btn_select_i(btn[0]), .btn_confirm_i(btn[1]), .btn_lase_i(btn[2]),
        .knob_step_i, .knob_up_i, .knob_press_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .laser_cmd_o, .lase_led_o, .gate_pull_up_o, .setup_active_o, .menu_item_o, .duty_o);
    gpc_rf_supply_model rf (.core_clk_i, .cmd_i(laser_cmd_o), .clr_i(clr), .max_hi_o(max_hi));

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register read", e, rd_val & m)
    endtask

    task automatic press(input logic [2:0] b);
        @(posedge core_clk_i);
        btn <= b;
        repeat (3) @(posedge core_clk_i);
        btn <= 3'h0;
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic knob(input logic up, input logic prs, input logic [7:0] e);
        @(posedge core_clk_i);
        {knob_step_i, knob_up_i, knob_press_i} <= {1'b1, up, prs};
        @(posedge core_clk_i);
        knob_step_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        `CHK("duty", e, duty_o)
    endtask

    // first half lets cut or mixed-rate pulses die out; longest run finished in the second half
    task automatic meas(input int n, input int e);
        @(posedge core_clk_i);
        clr <= 1'b1;
        repeat (n / 2) @(posedge core_clk_i);
        clr <= 1'b0;
        repeat (n - n / 2) @(posedge core_clk_i);
        `CHK("pulse length", e, max_hi)
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        // tests need about 91000 cycles
        repeat (98000) @(posedge core_clk_i);
        err_count++;
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(gpc_pkg::OFF_CONFIG, 32'h1f, 32'h0);
        `CHK("pull-up", 1'b1, gate_pull_up_o)
        rd(gpc_pkg::OFF_STATUS, 32'h8, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, rd_err)
        meas(1000, 100);
        $display("test defaults done");
        knob(1'b1, 1'b0, 8'h01);
        knob(1'b1, 1'b1, 8'h0b);
        knob(1'b0, 1'b1, 8'h01);
        apb(1'b1, gpc_pkg::OFF_DUTY, 32'hff);
        rd(gpc_pkg::OFF_DUTY, 32'hff, 32'hbe);
        apb(1'b1, gpc_pkg::OFF_CONFIG, 32'h08);
        apb(1'b1, gpc_pkg::OFF_DUTY, 32'hff);
        rd(gpc_pkg::OFF_DUTY, 32'hff, 32'hc6);
        apb(1'b1, gpc_pkg::OFF_CONFIG, 32'h00);
        rd(gpc_pkg::OFF_DUTY, 32'hff, 32'hbe);
        $display("test duty done");
        press(3'b100);
        rd(gpc_pkg::OFF_STATUS, 32'h8, 32'h8);
        for (int f = 0; f < 3; f++)
        begin
            apb(1'b1, gpc_pkg::OFF_CONFIG, f);
            // settle half outlasts one new-rate period after the switch
            meas(410 * slot[f], 190 * slot[f]);
        end
        `CHK("lase led", 1'b1, lase_led_o)
        gate_i <= 1'b0;
        meas(2000, 100);
        apb(1'b1, gpc_pkg::OFF_CONFIG, 32'h06);
        repeat (2) @(posedge core_clk_i);
        `CHK("pull-up", 1'b0, gate_pull_up_o)
        meas(2000, 100);
        gate_i <= 1'b1;
        meas(12000, 4750);
        press(3'b100);
        meas(2000, 100);
        $display("test firing done");
        apb(1'b1, gpc_pkg::OFF_CONFIG, 32'h19);
        press(3'b011);
        `CHK("setup", 1'b1, setup_active_o)
        repeat (4) press(3'b001);
        `CHK("menu item", 3'h4, menu_item_o)
        press(3'b010);
        `CHK("setup", 1'b0, setup_active_o)
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // confirm held through the version screen
        btn <= 3'h2;
        rd(gpc_pkg::OFF_CONFIG, 32'h1f, 32'h19);
        rd(gpc_pkg::OFF_DUTY, 32'hff, 32'hbe);
        rd(gpc_pkg::OFF_STATUS, 32'h8, 32'h8);
        `CHK("setup", 1'b1, setup_active_o)
        $display("test setup done");
        end_sim();
    end
endmodule
